// >>> logic/ddr_mode_pkg.sv
`default_nettype none
package ddr_mode_pkg;
   // ---------------------------------------------------------------
   // Link pin widths
   // ---------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int BA_W = 2;
   localparam int WORD_W = ADDR_W + BA_W;

   // ---------------------------------------------------------------
   // Controller register map (byte addresses, one word each)
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_BASE = 8'h08;
   localparam logic [7:0] REG_EXT = 8'h0C;
   localparam int CTRL_CKE = 0;
   localparam int CTRL_GO_BASE = 1;
   localparam int CTRL_GO_EXT = 2;
   localparam int CTRL_GO_REF = 3;
   localparam int CTRL_GO_PRE = 4;
   localparam int STAT_BUSY = 0;
   localparam int STAT_EXT_DONE = 1;
   localparam int STAT_IDLE = 2;
   localparam int STAT_LOCKED = 3;
   localparam int STAT_ERR = 4;
   localparam int STAT_REFS = 5;
   localparam int BASE_VAL_W = 9;
   localparam int EXT_VAL_W = 3;
   localparam logic [BASE_VAL_W-1:0] BASE_RESET = 9'h000;
   localparam logic [EXT_VAL_W-1:0] EXT_RESET = 3'h0;

   // ---------------------------------------------------------------
   // Address bit positions within a load or precharge command
   // ---------------------------------------------------------------
   localparam int A_BL_LSB = 0;
   localparam int A_BT = 3;
   localparam int A_LAT_LSB = 4;
   localparam int A_TEST = 7;
   localparam int A_DLL_RST = 8;
   localparam int A_DLL_DIS = 0;
   localparam int A_DRV_LO = 1;
   localparam int A_DRV_HI = 6;
   localparam int A_PRE_ALL = 10;
   localparam int BA_EXT_SEL = 0;

   // ---------------------------------------------------------------
   // Command codes as {cs_n, ras_n, cas_n, we_n}
   // ---------------------------------------------------------------
   localparam logic [3:0] CMD_LOAD = 4'h0;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_DESEL = 4'hF;

   // ---------------------------------------------------------------
   // Counts in link clock cycles, minimum refresh count, and divider default
   // ---------------------------------------------------------------
   localparam int MRD_CYCLES = 2;
   localparam int DLL_LOCK_CYCLES = 200;
   localparam int MIN_REFRESH = 2;
   localparam int TRP_DEFAULT = 5;
   localparam int TRFC_DEFAULT = 17;
   localparam int CK_HALF_DEFAULT = 8;

   // ---------------------------------------------------------------
   // Field encodings
   // ---------------------------------------------------------------
   localparam logic [2:0] BL_CODE_2 = 3'h1;
   localparam logic [2:0] BL_CODE_4 = 3'h2;
   localparam logic [2:0] BL_CODE_8 = 3'h3;
   localparam logic [2:0] LAT_CODE_3 = 3'h3;

   typedef enum logic [2:0] {OP_NONE, OP_BASE, OP_EXT, OP_REF, OP_PRE} op_t;

   function automatic logic [3:0] burst_beats_of(input logic [2:0] code);
      unique case (code)
         BL_CODE_2: burst_beats_of = 4'h2;
         BL_CODE_4: burst_beats_of = 4'h4;
         BL_CODE_8: burst_beats_of = 4'h8;
         default: burst_beats_of = 4'h0;
      endcase
   endfunction

   function automatic logic [2:0] latency_of(input logic [2:0] code);
      latency_of = (code == LAT_CODE_3) ? 3'h3 : 3'h0;
   endfunction
endpackage
`default_nettype wire

// >>> logic/ddr_mode_link.sv
`timescale 1ns/100ps
`default_nettype none
interface ddr_mode_link;
   import ddr_mode_pkg::*;
   logic ck;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [ADDR_W-1:0] addr;
   logic [BA_W-1:0] bank_addr;
   modport ctrl (output ck, cke, cs_n, ras_n, cas_n, we_n, addr, bank_addr);
   modport mem (input ck, cke, cs_n, ras_n, cas_n, we_n, addr, bank_addr);
endinterface
`default_nettype wire

// >>> logic/link_sampler.sv
`timescale 1ns/100ps
`default_nettype none
module link_sampler #(
   parameter int W = 2
) (
   input wire logic pclk, // System clock
   input wire logic presetn, // Async reset, active low
   input wire logic [W-1:0] din, // Raw pins, bit 0 is the link clock
   output logic [W-1:0] dout, // Synchronised pins
   output logic ck_rise // One-cycle pulse per link clock rise
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic ck_d;
   } samp_state_t;
   samp_state_t r;
   samp_state_t next_r;

   if (W < 2) begin : g_bad_width
      $error("link_sampler needs clock plus data");
   end

   always_comb begin
      next_r = r;
      next_r.s1 = din;
      next_r.s2 = r.s1;
      next_r.ck_d = r.s2[0];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // Pins change at the link clock's fall, so they are settled at its rise
   assign dout = r.s2;
   assign ck_rise = r.s2[0] & ~r.ck_d;
endmodule // link_sampler
`default_nettype wire

// >>> logic/ddr_mode_mem.sv
`timescale 1ns/100ps
`default_nettype none
module ddr_mode_mem
   import ddr_mode_pkg::*;
(
   input wire logic pclk, // System clock
   input wire logic presetn, // Async reset, active low
   ddr_mode_link.mem link, // Command pins from the controller
   output logic [WORD_W-1:0] base_word, // Stored {bank_addr, addr} of base load
   output logic [WORD_W-1:0] ext_word, // Stored {bank_addr, addr} of extended load
   output logic base_valid, // Base register written since reset
   output logic ext_valid, // Extended register written since reset
   output logic [2:0] burst_len_code, // Burst length field
   output logic [3:0] burst_beats, // Decoded beats, 0 if unsupported
   output logic burst_interleaved, // Burst type, 1 = interleaved
   output logic [2:0] latency_code, // Read latency field
   output logic [2:0] latency_clocks, // Decoded latency, 0 if unsupported
   output logic test_mode, // Test mode bit
   output logic dll_reset, // One-cycle pulse: loop reset requested
   output logic dll_enable, // Loop enabled (extended load seen, address bit 0 low)
   output logic [1:0] drive_sel // Driver strength {A6, A1}
);
   typedef struct packed {
      logic [WORD_W-1:0] base;
      logic [WORD_W-1:0] ext;
      logic bv;
      logic ev;
      logic dll_rst;
   } mem_state_t;
   mem_state_t r;
   mem_state_t next_r;
   logic [WORD_W+5-1:0] pins;
   logic ck_rise;
   logic ck_sync;
   logic [3:0] cmd;
   logic [ADDR_W-1:0] a;
   logic [BA_W-1:0] ba;

   // ---------------------------------------------------------------
   // Pin sampling
   // ---------------------------------------------------------------
   link_sampler #(.W(WORD_W + 6)) u_samp (
      .pclk(pclk),
      .presetn(presetn),
      .din({link.bank_addr, link.addr, link.cs_n, link.ras_n, link.cas_n, link.we_n,
            link.cke, link.ck}),
      .dout({pins, ck_sync}),
      .ck_rise(ck_rise)
   );
   assign ba = pins[WORD_W+4 -: BA_W];
   assign a = pins[ADDR_W+4 : 5];
   assign cmd = pins[4:1];

   // ---------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.dll_rst = 1'b0;
      // Ignored while clock enable is low or chip select is high
      if (ck_rise && ck_sync && pins[0] && cmd == CMD_LOAD) begin
         if (!ba[BA_EXT_SEL]) begin
            next_r.base = {ba, a};
            next_r.bv = 1'b1;
            next_r.dll_rst = a[A_DLL_RST];
         end else begin
            next_r.ext = {ba, a};
            next_r.ev = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign base_word = r.base;
   assign ext_word = r.ext;
   assign base_valid = r.bv;
   assign ext_valid = r.ev;
   assign burst_len_code = r.base[A_BL_LSB +: 3];
   assign burst_beats = burst_beats_of(r.base[A_BL_LSB +: 3]);
   assign burst_interleaved = r.base[A_BT];
   assign latency_code = r.base[A_LAT_LSB +: 3];
   assign latency_clocks = latency_of(r.base[A_LAT_LSB +: 3]);
   assign test_mode = r.base[A_TEST];
   assign dll_reset = r.dll_rst;
   assign dll_enable = r.ev & ~r.ext[A_DLL_DIS];
   assign drive_sel = {r.ext[A_DRV_HI], r.ext[A_DRV_LO]};
endmodule // ddr_mode_mem
`default_nettype wire

// >>> logic/ddr_mode_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - base load: all four command pins low
// - memory stores address and bank bits
// - two clocks after base load
// - base load only with banks idle
// - burst length from bits 0 to 2
// - burst type from bit 3
// - read latency from bits 4 to 6
// - bits 7, 8, bank low normally
// - bit 8 high resets the loop
// - base load only after extended load
// - clock enable high before base load
// - precharge time before base load
// - extended load: bank bit 0 high
// - memory stores extended address bits
// - bit 0 enables or disables loop
// - bits 1 and 6 select drive
// - other extended bits driven low
// - two clocks after extended load
// - extended load: banks idle, enable high
// - extended load required after power-up
// - 200 clocks for loop lock
// - two refreshes before final base load
module ddr_mode_ctrl
   import ddr_mode_pkg::*;
#(
   parameter int CK_HALF = CK_HALF_DEFAULT,
   parameter int TRP_CK = TRP_DEFAULT,
   parameter int TRFC_CK = TRFC_DEFAULT
) (
   input wire logic pclk, // System clock
   input wire logic presetn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction, 1 = write
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error for unmapped address
   ddr_mode_link.ctrl link // Command pins to the memory
);
   typedef enum logic [1:0] {S_IDLE, S_CMD, S_WAIT} ctrl_phase_t;
   typedef struct packed {
      logic [7:0] div;
      logic ck;
      logic cke_en;
      logic [3:0] cmd;
      logic [ADDR_W-1:0] addr;
      logic [BA_W-1:0] ba;
      logic [BASE_VAL_W-1:0] base_val;
      logic [EXT_VAL_W-1:0] ext_val;
      op_t pend;
      op_t cur;
      ctrl_phase_t st;
      logic [7:0] wait_cnt;
      logic [7:0] lock_cnt;
      logic [1:0] refs;
      logic ext_done;
      logic banks_idle;
      logic dll_rst_pend;
      logic dll_on;
      logic err;
      logic [31:0] rdata;
      logic slverr;
   } ctrl_state_t;
   ctrl_state_t r;
   ctrl_state_t next_r;
   logic wrap;
   logic rise_en;
   logic fall_en;
   logic setup;
   logic wr;
   logic mapped;
   logic busy;
   logic locked;
   logic ok_base;
   logic ok_ext;
   op_t go_op;
   logic go_ok;
   logic [31:0] status;

   if (CK_HALF < 2 || CK_HALF > 255 || TRP_CK < 2 || TRP_CK > 255 ||
       TRFC_CK < 2 || TRFC_CK > 255) begin : g_bad_param
      $error("ddr_mode_ctrl parameter out of range");
   end

   // ---------------------------------------------------------------
   // Link clock divider and bus decode
   // ---------------------------------------------------------------
   assign wrap = (r.div == 8'(CK_HALF - 1));
   assign rise_en = wrap & ~r.ck;
   assign fall_en = wrap & r.ck;
   assign setup = psel & ~penable;
   assign wr = psel & penable & pwrite & mapped;
   assign mapped = (paddr == REG_CTRL) || (paddr == REG_STATUS) ||
                   (paddr == REG_BASE) || (paddr == REG_EXT);
   assign busy = (r.st != S_IDLE) || (r.pend != OP_NONE);
   assign locked = r.dll_on & (r.lock_cnt == 8'h00);

   // Extended load must precede base load; final load waits for refreshes
   assign ok_base = r.cke_en & r.banks_idle & r.ext_done &
                    ~(r.dll_rst_pend & ~r.base_val[A_DLL_RST] &
                      (r.refs < 2'(MIN_REFRESH)));
   assign ok_ext = r.cke_en & r.banks_idle;

   assign go_op = pwdata[CTRL_GO_BASE] ? OP_BASE :
                  pwdata[CTRL_GO_EXT] ? OP_EXT :
                  pwdata[CTRL_GO_REF] ? OP_REF :
                  pwdata[CTRL_GO_PRE] ? OP_PRE : OP_NONE;
   assign go_ok = (go_op == OP_BASE) ? ok_base :
                  (go_op == OP_EXT || go_op == OP_REF) ? ok_ext :
                  (go_op == OP_PRE) ? r.cke_en : 1'b0;

   always_comb begin
      status = 32'h0000_0000;
      status[STAT_BUSY] = busy;
      status[STAT_EXT_DONE] = r.ext_done;
      status[STAT_IDLE] = r.banks_idle;
      status[STAT_LOCKED] = locked;
      status[STAT_ERR] = r.err;
      status[STAT_REFS +: 2] = r.refs;
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.div = wrap ? 8'h00 : r.div + 8'h01;
      if (wrap) begin
         next_r.ck = ~r.ck;
      end
      if (rise_en) begin
         if (r.st == S_WAIT && r.wait_cnt != 8'h00) begin
            next_r.wait_cnt = r.wait_cnt - 8'h01;
         end
         if (r.lock_cnt != 8'h00) begin
            next_r.lock_cnt = r.lock_cnt - 8'h01;
         end
      end
      // Commands start at the link clock's fall so they are centred on its rise
      unique case (r.st)
         S_IDLE: begin
            if (fall_en && r.pend != OP_NONE) begin
               next_r.st = S_CMD;
               next_r.cur = r.pend;
               next_r.pend = OP_NONE;
               next_r.addr = '0;
               next_r.ba = '0;
               unique case (r.pend)
                  OP_BASE: begin
                     next_r.cmd = CMD_LOAD;
                     // Bank bits and bits above 8 stay low
                     next_r.addr[BASE_VAL_W-1:0] = r.base_val;
                     next_r.dll_rst_pend = r.base_val[A_DLL_RST];
                     if (r.base_val[A_DLL_RST]) begin
                        next_r.refs = 2'h0;
                        next_r.lock_cnt = 8'(DLL_LOCK_CYCLES);
                     end
                  end
                  OP_EXT: begin
                     next_r.cmd = CMD_LOAD;
                     next_r.ba[BA_EXT_SEL] = 1'b1;
                     // Only loop and drive bits may be high
                     next_r.addr[A_DLL_DIS] = r.ext_val[0];
                     next_r.addr[A_DRV_LO] = r.ext_val[1];
                     next_r.addr[A_DRV_HI] = r.ext_val[2];
                     next_r.ext_done = 1'b1;
                     next_r.dll_on = ~r.ext_val[0];
                     if (!r.ext_val[0]) begin
                        next_r.lock_cnt = 8'(DLL_LOCK_CYCLES);
                     end
                  end
                  OP_REF: begin
                     next_r.cmd = CMD_REF;
                     if (r.refs != 2'h3) begin
                        next_r.refs = r.refs + 2'h1;
                     end
                  end
                  OP_PRE: begin
                     next_r.cmd = CMD_PRE;
                     next_r.addr[A_PRE_ALL] = 1'b1;
                     next_r.banks_idle = 1'b1;
                  end
                  default: next_r.cmd = CMD_DESEL;
               endcase
            end
         end
         S_CMD: begin
            if (fall_en) begin
               next_r.cmd = CMD_DESEL;
               next_r.addr = '0;
               next_r.ba = '0;
               next_r.st = S_WAIT;
               // One rise has passed already; count the remainder
               unique case (r.cur)
                  OP_PRE: next_r.wait_cnt = 8'(TRP_CK - 1);
                  OP_REF: next_r.wait_cnt = 8'(TRFC_CK - 1);
                  default: next_r.wait_cnt = 8'(MRD_CYCLES - 1);
               endcase
            end
         end
         S_WAIT: begin
            if (r.wait_cnt == 8'h00) begin
               next_r.st = S_IDLE;
               next_r.cur = OP_NONE;
            end
         end
      endcase
      // Bus side: read data is captured in the setup cycle
      if (setup) begin
         next_r.slverr = ~mapped;
         next_r.rdata = 32'h0000_0000;
         if (paddr == REG_CTRL) begin
            next_r.rdata[CTRL_CKE] = r.cke_en;
         end else if (paddr == REG_STATUS) begin
            next_r.rdata = status;
         end else if (paddr == REG_BASE) begin
            next_r.rdata[BASE_VAL_W-1:0] = r.base_val;
         end else if (paddr == REG_EXT) begin
            next_r.rdata[EXT_VAL_W-1:0] = r.ext_val;
         end
      end
      if (wr && paddr == REG_STATUS && pwdata[STAT_ERR]) begin
         next_r.err = 1'b0;
      end
      if (wr && paddr == REG_BASE) begin
         next_r.base_val = pwdata[BASE_VAL_W-1:0];
      end
      if (wr && paddr == REG_EXT) begin
         next_r.ext_val = pwdata[EXT_VAL_W-1:0];
      end
      if (wr && paddr == REG_CTRL) begin
         next_r.cke_en = pwdata[CTRL_CKE];
         if (go_op != OP_NONE) begin
            if (busy || !go_ok) begin
               next_r.err = 1'b1;
            end else begin
               next_r.pend = go_op;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{div: 8'h00, ck: 1'b0, cke_en: 1'b0, cmd: CMD_DESEL, addr: '0, ba: '0,
                base_val: BASE_RESET, ext_val: EXT_RESET, pend: OP_NONE, cur: OP_NONE,
                st: S_IDLE, wait_cnt: 8'h00, lock_cnt: 8'h00, refs: 2'h0,
                ext_done: 1'b0, banks_idle: 1'b0, dll_rst_pend: 1'b0, dll_on: 1'b0,
                err: 1'b0, rdata: 32'h0000_0000, slverr: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign prdata = r.rdata;
   assign pready = psel & penable;
   assign pslverr = psel & penable & r.slverr;
   assign link.ck = r.ck;
   assign link.cke = r.cke_en;
   assign link.cs_n = r.cmd[3];
   assign link.ras_n = r.cmd[2];
   assign link.cas_n = r.cmd[1];
   assign link.we_n = r.cmd[0];
   assign link.addr = r.addr;
   assign link.bank_addr = r.ba;
endmodule // ddr_mode_ctrl
`default_nettype wire

// >>> sim/ddr_mode_props.sv
`timescale 1ns/100ps
`default_nettype none
module ddr_mode_props
   import ddr_mode_pkg::*;
#(
   parameter int CK_HALF = CK_HALF_DEFAULT, // Half period of the link clock in pclk cycles
   parameter int TRP_CK = TRP_DEFAULT // Precharge recovery in link clocks
) (
   input wire logic pclk, // System clock
   input wire logic presetn, // Async reset, active low
   input wire logic ck, // Link clock
   input wire logic cke, // Clock enable
   input wire logic cs_n, // Chip select
   input wire logic ras_n, // Row strobe
   input wire logic cas_n, // Column strobe
   input wire logic we_n, // Write enable
   input wire logic [ADDR_W-1:0] addr, // Address pins
   input wire logic [BA_W-1:0] bank_addr // Bank pins
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ---------------------------------------------------------------
   // Helper state, advanced at each link clock rise, except ck_q and low_len, which advance every pclk
   // ---------------------------------------------------------------
   wire logic [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
   logic ck_q, ext_seen, rst_pend, pre_seen;
   logic [7:0] gap, low_len;
   logic [3:0] last;
   logic [1:0] refs;
   wire logic rise = ck && !ck_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ck_q <= 1'b0;
         ext_seen <= 1'b0;
         rst_pend <= 1'b0;
         pre_seen <= 1'b0;
         gap <= 8'hFF;
         low_len <= 8'h00;
         last <= CMD_DESEL;
         refs <= 2'h0;
      end else begin
         ck_q <= ck;
         if (rise && cmd == CMD_PRE) begin
            pre_seen <= 1'b1;
         end
         low_len <= cs_n ? 8'h00 : low_len + 8'h01;
         if (rise && !cs_n) begin
            last <= cmd;
            gap <= 8'h01;
         end else if (rise && gap != 8'hFF) begin
            gap <= gap + 8'h01;
         end
         if (rise && cmd == CMD_LOAD && bank_addr[BA_EXT_SEL]) begin
            ext_seen <= 1'b1;
         end
         if (rise && cmd == CMD_LOAD && !bank_addr[BA_EXT_SEL] && addr[A_DLL_RST]) begin
            rst_pend <= 1'b1;
            refs <= 2'h0;
         end else if (rise && cmd == CMD_REF && refs != 2'h3) begin
            refs <= refs + 2'h1;
         end
      end
   end
   sequence ext_load;
      rise && cmd == CMD_LOAD && bank_addr[BA_EXT_SEL];
   endsequence
   sequence base_load;
      rise && cmd == CMD_LOAD && !bank_addr[BA_EXT_SEL];
   endsequence
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   a_pins_on_fall: assert property ($changed({cmd, addr, bank_addr}) |-> $fell(ck))
      else $error("command pins moved away from a link clock fall");
   a_cmd_full_period: assert property ($rose(cs_n) |-> low_len == 2 * CK_HALF)
      else $error("command did not stand one link clock period");
   a_load_gap_two: assert property (rise && !cs_n && last == CMD_LOAD |-> gap >= 8'h02)
      else $error("command followed a load too soon");
   a_trp_before_load: assert property (base_load and (last == CMD_PRE) |-> gap >= TRP_CK)
      else $error("load issued inside the precharge time");
   a_ext_fields_low: assert property (ext_load |-> (addr & 12'hFBC) == 12'h000 && !bank_addr[1])
      else $error("extended load drove a reserved position high");
   a_base_bank_low: assert property (base_load |-> bank_addr == 2'h0 && addr[11:9] == 3'h0)
      else $error("base load drove bank or high address bits");
   a_cke_already_high: assert property (rise && cmd == CMD_LOAD |-> cke && $past(cke, 3))
      else $error("load issued without clock enable held high");
   a_ext_before_base: assert property (base_load |-> ext_seen)
      else $error("base load before any extended load");
   a_load_banks_idle: assert property (rise && cmd == CMD_LOAD |-> pre_seen)
      else $error("load issued before banks were precharged");
   a_refresh_then_base: assert property (base_load and (!addr[A_DLL_RST] && rst_pend) |-> refs >= 2'h2)
      else $error("final base load without two refreshes");
endmodule // ddr_mode_props
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
   import ddr_mode_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic rst_seen = 1'b0;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, s;
   logic [WORD_W-1:0] base_word, ext_word;
   logic base_valid, ext_valid, burst_interleaved, test_mode, dll_reset, dll_enable;
   logic [2:0] burst_len_code, latency_code, latency_clocks, k;
   logic [3:0] burst_beats;
   logic [1:0] drive_sel;
   logic [8:0] bv [3] = '{9'h031, 9'h0BB, 9'h027};
   logic [3:0] bb [3] = '{4'h2, 4'h8, 4'h0};
   logic [2:0] bl [3] = '{3'h3, 3'h3, 3'h0};
   int mismatches = 0;
   int checked = 0;
   ddr_mode_link link();
   ddr_mode_ctrl #(.CK_HALF(2)) ddr_mode_ctrl_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
   ddr_mode_mem ddr_mode_mem_inst (.pclk(pclk), .presetn(presetn), .link(link),
      .base_word(base_word), .ext_word(ext_word), .base_valid(base_valid),
      .ext_valid(ext_valid), .burst_len_code(burst_len_code), .burst_beats(burst_beats),
      .burst_interleaved(burst_interleaved), .latency_code(latency_code),
      .latency_clocks(latency_clocks), .test_mode(test_mode), .dll_reset(dll_reset),
      .dll_enable(dll_enable), .drive_sel(drive_sel));
   ddr_mode_props #(.CK_HALF(2), .TRP_CK(TRP_DEFAULT)) ddr_mode_props_inst (.pclk(pclk),
      .presetn(presetn), .ck(link.ck), .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
      .cas_n(link.cas_n), .we_n(link.we_n), .addr(link.addr), .bank_addr(link.bank_addr));
   // ---------------------------------------------------------------
   // Bus tasks
   // ---------------------------------------------------------------
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0, q, e);
   endtask
   // Memory registers settle a few pclk after the sampling rise
   task automatic go(input logic [31:0] c);
      wr(REG_CTRL, c);
      s = 32'h1;
      while (s[STAT_BUSY] !== 1'b0) rd(REG_STATUS, s);
      repeat (8) @(posedge pclk);
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      if (mismatches == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge pclk) if (dll_reset === 1'b1) rst_seen <= 1'b1;
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      end_sim();
   end
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] q;
      logic e;
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check({base_valid, ext_valid}, 2'b00);
      apb(1'b0, 8'h10, 32'h0, q, e);
      check(q, 32'h0000_0000);
      check(e, 1'b1);
      go(32'h05); // Clock enable and load in one write
      rd(REG_STATUS, s);
      check({s[STAT_ERR], ext_valid}, 2'b10);
      wr(REG_STATUS, 32'h10);
      go(32'h01);
      go(32'h11);
      go(32'h03); // Base before any extended load
      rd(REG_STATUS, s);
      check({s[STAT_ERR], base_valid}, 2'b10);
      wr(REG_STATUS, 32'h10);
      for (int i = 7; i >= 0; i--) begin
         k = i[2:0];
         wr(REG_EXT, {29'h0, k});
         go(32'h05);
         check(ext_word, {2'b01, 5'h00, k[2], 4'h0, k[1], k[0]});
         check({dll_enable, drive_sel}, {~k[0], k[2], k[1]});
      end
      wr(REG_BASE, 32'h132);
      go(32'h03);
      check(base_word, 14'h0132);
      check({burst_beats, burst_interleaved, latency_clocks, rst_seen}, 9'h087);
      rd(REG_STATUS, s);
      check(s[STAT_LOCKED], 1'b0);
      wr(REG_BASE, 32'h031);
      go(32'h03); // Loop reset pending and no refresh yet
      rd(REG_STATUS, s);
      check({s[STAT_ERR], base_word}, {1'b1, 14'h0132});
      wr(REG_STATUS, 32'h10);
      go(32'h09);
      go(32'h09);
      rd(REG_STATUS, s);
      check(s[6:5], 2'h2);
      go(32'h11);
      for (int i = 0; i < 3; i++) begin
         wr(REG_BASE, {23'h0, bv[i]});
         go(32'h03);
         check(base_word, {5'h00, bv[i]});
         check({burst_beats, latency_clocks}, {bb[i], bl[i]});
         check({burst_interleaved, test_mode}, {bv[i][3], bv[i][7]});
         check({burst_len_code, latency_code}, {bv[i][2:0], bv[i][6:4]});
      end
      repeat (900) @(posedge pclk);
      rd(REG_STATUS, s);
      check(s[STAT_LOCKED], 1'b1);
      end_sim();
   end
endmodule // testbench
`default_nettype wire
